// >>> cmb_pkg.sv
package cmb_pkg;

    // Register indices on the 16-bit register port (word addresses)
    localparam logic [4:0] ADDR_FMSEL_LO   = 5'h00;
    localparam logic [4:0] ADDR_FMSEL_HI   = 5'h01;
    localparam logic [4:0] ADDR_MSK0_SID   = 5'h02;
    localparam logic [4:0] ADDR_MSK0_EID   = 5'h03;
    localparam logic [4:0] ADDR_MSK1_SID   = 5'h04;
    localparam logic [4:0] ADDR_MSK1_EID   = 5'h05;
    localparam logic [4:0] ADDR_MSK2_SID   = 5'h06;
    localparam logic [4:0] ADDR_MSK2_EID   = 5'h07;
    localparam logic [4:0] ADDR_FULL_LO    = 5'h08;
    localparam logic [4:0] ADDR_FULL_HI    = 5'h09;
    localparam logic [4:0] ADDR_OVF_LO     = 5'h0A;
    localparam logic [4:0] ADDR_OVF_HI     = 5'h0B;
    localparam logic [4:0] ADDR_TRCON0     = 5'h0C;
    localparam logic [4:0] ADDR_FLT_EN     = 5'h10;
    localparam logic [4:0] ADDR_FLT_PTR0   = 5'h11;
    localparam logic [4:0] ADDR_FLT_SID0   = 5'h15;
    localparam logic [4:0] ADDR_FLT_EID0   = 5'h16;

    // Field positions in mask and filter STANDARD_IDENTIFIER words
    localparam int SID_LSB      = 5;
    localparam int IDTYPE_BIT   = 3;
    localparam int EIDHI_MSB    = 1;

    // Field positions in a buffer control byte
    localparam int CTL_DIR      = 7;
    localparam int CTL_ABT      = 6;
    localparam int CTL_LARB     = 5;
    localparam int CTL_ERR      = 4;
    localparam int CTL_REQ      = 3;
    localparam int CTL_RTR      = 2;

    // Reset values and identifier write mask
    localparam logic [15:0] RST_ZERO    = 16'h0000;
    localparam logic [15:0] RST_FLT_EN  = 16'hFFFF;
    localparam logic [15:0] SID_WMASK   = 16'hFFEB;

    // Mask source selector codes and FIFO pointer code
    localparam logic [1:0] MSRC_SET0    = 2'h0;
    localparam logic [1:0] MSRC_SET1    = 2'h1;
    localparam logic [1:0] MSRC_SET2    = 2'h2;
    localparam logic [3:0] PTR_FIFO     = 4'hF;

    // Received frame header from the protocol engine
    typedef struct packed {
        logic [10:0] standard_identifier;
        logic [17:0] extended_identifier;
        logic        ext;
        logic        rtr;
    } cmb_frame_t;

    // Per-buffer outcome of a transmit attempt
    typedef struct packed {
        logic       done;
        logic       aborted;
        logic       lost_arb;
        logic       bus_err;
        logic [2:0] buf_idx;
    } cmb_tx_result_t;

endpackage

// >>> cmb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Per filter 2-bit mask source: 00 set 0, 01 set 1, 10 set 2, 11 reserved.
// - Filters 8..15 selectors in second register, filter 15 at top pair.
// - Standard mask bit one compares identifier bit, zero makes it don't-care.
// - Eighteen extended mask bits include or exclude their identifier bit.
// - Type bit one: frame type must equal the filter's extended select.
// - Type bit zero: both frame types accepted if compared bits match.
// - Three independent mask sets, each a standard and an extended word.
// - Store into buffer sets its full flag; 32 flags in two registers.
// - Store into still-full buffer sets its overflow flag.
// - Direction bit: one transmit, zero receive, resets zero.
// - Aborted status set on abort, read-only, clear on success.
// - Lost-arbitration status set when message loses arbitration.
// - Transmit-error status set on bus error while sending.
// - All three status bits clear when send request becomes set.
// - Software sets send request; hardware clears it on success.
// - Zero written to a set send request asks for abort.
// - Auto-remote enable with matching remote frame sets send request, in a transmit buffer only.
// - Two-bit priority per buffer, 11 highest, 00 lowest.
// - Control register pairs even buffer low byte, odd buffer high byte.
// - Identifier, length, payload, status words live in DMA RAM.
// - Each compared identifier bit must equal the filter's stored bit.
// - With type bit set, extended select one matches extended only.
// - A filter takes part only while its enable bit is one.
// - Four-bit buffer pointer steers hit to buffer 0..14, 1111 to FIFO.

// Register word map
// 00 mask select, filters 0-7
// 01 mask select, filters 8-15
// 02 mask set 0 standard word
// 03 mask set 0 extended word
// 04 mask set 1 standard word
// 05 mask set 1 extended word
// 06 mask set 2 standard word
// 07 mask set 2 extended word
// 08 full flags, buffers 0-15
// 09 full flags, buffers 16-31
// 0A overflow flags, 0-15
// 0B overflow flags, 16-31
// 0C-0F buffer pair control
// 10 filter enables
// 11-14 buffer pointers
// 15 filter standard word
// 16 filter extended word
// 17 filter index, bits 3:0
// 18-1F unmapped, read zero
// Filter words are write only
// Control byte: 7 direction,
// 6:4 status, 3 request,
// 2 remote reply, 1:0 priority
module cmb_ctrl
    import cmb_pkg::*;
#(
    parameter int NUM_FLT = 16,
    parameter int NUM_TRB = 8
) (
    input  wire logic                clk_i,
    input  wire logic                nrst_i,
    input  wire logic [4:0]          addr_i,
    input  wire logic [15:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [15:0]         rdata_o,
    input  wire logic                frm_valid_i,
    input  wire cmb_pkg::cmb_frame_t frm_i,
    input  wire logic                store_i,
    input  wire logic [4:0]          store_buf_i,
    input  wire cmb_pkg::cmb_tx_result_t tx_res_i,
    output logic                     hit_o,
    output logic      [3:0]          hit_filter_o,
    output logic      [3:0]          hit_ptr_o,
    output logic      [NUM_TRB-1:0]  tx_req_o,
    output logic      [NUM_TRB-1:0]  tx_abort_o,
    output logic      [2*NUM_TRB-1:0] tx_pri_o,
    output logic      [NUM_TRB-1:0]  tx_dir_o
);
    import cmb_pkg::*;

    // Register map holds only 16 filters and 8 control buffers
    if (NUM_FLT != 16 || NUM_TRB != 8) begin : g_bad_size
        $error("cmb_ctrl supports 16 filters and 8 buffers only");
    end

    // Software-visible storage
    logic [31:0] fmsel_q;
    logic [15:0] msk_sid_q [3];
    logic [15:0] msk_eid_q [3];
    logic [15:0] flt_en_q;
    logic [63:0] flt_ptr_q;
    logic [15:0] flt_sid_q [16];
    logic [15:0] flt_eid_q [16];
    logic [31:0] full_q;
    logic [31:0] full_d;
    logic [31:0] ovf_q;
    logic [31:0] ovf_d;
    // Per-buffer control bytes
    logic [7:0]  ctl_q [8];
    logic [7:0]  ctl_d [8];
    logic [15:0] rdata_q;
    logic        hit_q;
    logic [3:0]  hit_flt_q;
    logic [3:0]  hit_ptr_q;
    logic [7:0]  abort_q;

    // Write decode
    wire wr_fmlo  = wr_i && addr_i == ADDR_FMSEL_LO;
    wire wr_fmhi  = wr_i && addr_i == ADDR_FMSEL_HI;
    wire wr_fulo  = wr_i && addr_i == ADDR_FULL_LO;
    wire wr_fuhi  = wr_i && addr_i == ADDR_FULL_HI;
    wire wr_ovlo  = wr_i && addr_i == ADDR_OVF_LO;
    wire wr_ovhi  = wr_i && addr_i == ADDR_OVF_HI;
    wire wr_fen   = wr_i && addr_i == ADDR_FLT_EN;
    wire wr_ctl   = wr_i && addr_i[4:2] == ADDR_TRCON0[4:2];
    wire [1:0] ctl_pair = addr_i[1:0];
    // Filter window: STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, then index; words above it are unmapped
    wire [4:0] flt_off  = 5'(addr_i - ADDR_FLT_SID0);
    wire       fid_wr   = wr_i && addr_i >= ADDR_FLT_SID0 &&
                          flt_off <= 5'h02;

    // Per-filter acceptance compare
    logic [15:0] flt_hit;
    genvar f;
    generate
        for (f = 0; f < 16; f++) begin : g_flt
            wire [1:0]  sel  = fmsel_q[2*f +: 2];
            // Selector 11 turns the filter off
            wire        sel_ok = sel != 2'h3;
            wire [1:0]  si   = (sel == MSRC_SET1) ? 2'd1 :
                               (sel == MSRC_SET2) ? 2'd2 : 2'd0;
            wire [15:0] ms   = msk_sid_q[si];
            wire [15:0] me   = msk_eid_q[si];
            wire [15:0] fs   = flt_sid_q[f];
            wire [15:0] fe   = flt_eid_q[f];
            wire [10:0] sidm = ms[15:SID_LSB];
            wire [17:0] eidm = {ms[EIDHI_MSB:0], me};
            // Masked compare: a zero mask bit is a don't-care
            wire sid_eq = ((fs[15:SID_LSB] ^ frm_i.standard_identifier) & sidm) == 11'h000;
            wire eid_eq = ((({fs[EIDHI_MSB:0], fe}) ^ frm_i.extended_identifier) & eidm) == 18'h00000;
            wire id_eq  = sid_eq && (!frm_i.ext || eid_eq);
            // Type check only when the mask asks for it
            wire type_ok = !ms[IDTYPE_BIT] || (fs[IDTYPE_BIT] == frm_i.ext);
            assign flt_hit[f] = flt_en_q[f] && sel_ok && id_eq && type_ok;
        end
    endgenerate

    // Lowest numbered enabled filter wins
    logic [3:0] win_idx;
    logic       any_hit;
    always_comb begin
        win_idx = 4'h0;
        any_hit = 1'b0;
        // Downward scan leaves the lowest hit
        for (int i = 15; i >= 0; i--) begin
            if (flt_hit[i]) begin
                win_idx = 4'(i);
                any_hit = 1'b1;
            end
        end
    end
    // Pointer of the winning filter
    wire [3:0] win_ptr = flt_ptr_q[4*win_idx +: 4];

    // Full and overflow flags; a store in the clearing cycle wins
    always_comb begin
        full_d = full_q;
        ovf_d  = ovf_q;
        // Write zero clears, write one keeps
        if (wr_fulo) begin
            full_d[15:0]  = full_q[15:0]  & wdata_i;
        end
        if (wr_fuhi) begin
            full_d[31:16] = full_q[31:16] & wdata_i;
        end
        if (wr_ovlo) begin
            ovf_d[15:0]   = ovf_q[15:0]   & wdata_i;
        end
        if (wr_ovhi) begin
            ovf_d[31:16]  = ovf_q[31:16]  & wdata_i;
        end
        // Store applied last so it beats a same-cycle clear
        if (store_i) begin
            if (full_q[store_buf_i]) begin
                ovf_d[store_buf_i] = 1'b1;
            end
            full_d[store_buf_i] = 1'b1;
        end
    end

    // Buffer control bytes: software writes, engine outcomes, remote replies
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_buf
            wire       wsel  = wr_ctl && ctl_pair == 2'(b / 2);
            wire [7:0] wbyte = (b % 2 == 1) ? wdata_i[15:8] : wdata_i[7:0];
            // Remote reply needs a transmit buffer
            wire       rtr_hit = any_hit && frm_valid_i && frm_i.rtr &&
                                 win_ptr == 4'(b) && ctl_q[b][CTL_RTR] &&
                                 ctl_q[b][CTL_DIR];
            wire       res   = tx_res_i.buf_idx == 3'(b);
            always_comb begin
                ctl_d[b] = ctl_q[b];
                if (wsel) begin
                    ctl_d[b][CTL_DIR] = wbyte[CTL_DIR];
                    ctl_d[b][CTL_RTR] = wbyte[CTL_RTR];
                    ctl_d[b][1:0]     = wbyte[1:0];
                    ctl_d[b][CTL_REQ] = wbyte[CTL_REQ];
                end
                // Engine outcomes come after the write, so they win
                if (res && tx_res_i.aborted) begin
                    ctl_d[b][CTL_ABT]  = 1'b1;
                end
                if (res && tx_res_i.lost_arb) begin
                    ctl_d[b][CTL_LARB] = 1'b1;
                end
                if (res && tx_res_i.bus_err) begin
                    ctl_d[b][CTL_ERR]  = 1'b1;
                end
                if (res && (tx_res_i.done || tx_res_i.aborted)) begin
                    ctl_d[b][CTL_REQ] = 1'b0;
                end
                if (res && tx_res_i.done) begin
                    ctl_d[b][CTL_ABT] = 1'b0;
                end
                // Remote reply set wins over both
                if (rtr_hit) begin
                    ctl_d[b][CTL_REQ] = 1'b1;
                end
                if (ctl_d[b][CTL_REQ] && !ctl_q[b][CTL_REQ]) begin
                    ctl_d[b][6:4] = 3'h0;
                end
            end
            // Control byte and abort pulse
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    ctl_q[b]   <= RST_ZERO[7:0];
                    abort_q[b] <= 1'b0;
                end else begin
                    ctl_q[b]   <= ctl_d[b];
                    // One-cycle pulse; the engine latches it
                    abort_q[b] <= wsel && ctl_q[b][CTL_REQ] && !wbyte[CTL_REQ];
                end
            end
            // Outputs straight from the control flops
            assign tx_req_o[b]          = ctl_q[b][CTL_REQ];
            assign tx_dir_o[b]          = ctl_q[b][CTL_DIR];
            assign tx_pri_o[2*b +: 2]   = ctl_q[b][1:0];
            assign tx_abort_o[b]        = abort_q[b];
        end
    endgenerate

    // Read mux; unmapped words read zero
    logic [15:0] rmux;
    always_comb begin
        rmux = 16'h0000;
        case (addr_i)
            ADDR_FMSEL_LO: rmux = fmsel_q[15:0];
            ADDR_FMSEL_HI: rmux = fmsel_q[31:16];
            ADDR_MSK0_SID: rmux = msk_sid_q[0];
            ADDR_MSK0_EID: rmux = msk_eid_q[0];
            ADDR_MSK1_SID: rmux = msk_sid_q[1];
            ADDR_MSK1_EID: rmux = msk_eid_q[1];
            ADDR_MSK2_SID: rmux = msk_sid_q[2];
            ADDR_MSK2_EID: rmux = msk_eid_q[2];
            ADDR_FULL_LO:  rmux = full_q[15:0];
            ADDR_FULL_HI:  rmux = full_q[31:16];
            ADDR_OVF_LO:   rmux = ovf_q[15:0];
            ADDR_OVF_HI:   rmux = ovf_q[31:16];
            ADDR_FLT_EN:   rmux = flt_en_q;
            default: begin
                // Both bytes of the pair in one word
                if (wr_ctl || addr_i[4:2] == ADDR_TRCON0[4:2]) begin
                    rmux = {ctl_q[2*ctl_pair+1], ctl_q[2*ctl_pair]};
                end else if (addr_i >= ADDR_FLT_PTR0 && addr_i < ADDR_FLT_SID0) begin
                    rmux = flt_ptr_q[16*(addr_i - ADDR_FLT_PTR0) +: 16];
                end
            end
        endcase
    end

    // Mask, filter and flag storage
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fmsel_q  <= {RST_ZERO, RST_ZERO};
            // Filters come out of reset enabled
            flt_en_q <= RST_FLT_EN;
            flt_ptr_q <= {4{RST_ZERO}};
            full_q   <= {RST_ZERO, RST_ZERO};
            ovf_q    <= {RST_ZERO, RST_ZERO};
            for (int i = 0; i < 3; i++) begin
                msk_sid_q[i] <= RST_ZERO;
                msk_eid_q[i] <= RST_ZERO;
            end
        end else begin
            full_q <= full_d;
            ovf_q  <= ovf_d;
            if (wr_fmlo) begin
                fmsel_q[15:0]  <= wdata_i;
            end
            if (wr_fmhi) begin
                fmsel_q[31:16] <= wdata_i;
            end
            if (wr_fen) begin
                flt_en_q <= wdata_i;
            end
            if (wr_i && addr_i >= ADDR_FLT_PTR0 && addr_i < ADDR_FLT_SID0) begin
                flt_ptr_q[16*(addr_i - ADDR_FLT_PTR0) +: 16] <= wdata_i;
            end
            // Unimplemented STANDARD_IDENTIFIER bits stay zero
            for (int i = 0; i < 3; i++) begin
                if (wr_i && addr_i == 5'(ADDR_MSK0_SID + 2*i)) begin
                    msk_sid_q[i] <= wdata_i & SID_WMASK;
                end
                if (wr_i && addr_i == 5'(ADDR_MSK0_EID + 2*i)) begin
                    msk_eid_q[i] <= wdata_i;
                end
            end
        end
    end

    // Filter identifiers are written through one indexed window pair
    // Index holds until rewritten
    logic [3:0] fid_idx_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fid_idx_q <= 4'h0;
            for (int i = 0; i < 16; i++) begin
                flt_sid_q[i] <= RST_ZERO;
                flt_eid_q[i] <= RST_ZERO;
            end
        end else if (fid_wr) begin
            if (flt_off == 5'h00) begin
                flt_sid_q[fid_idx_q] <= wdata_i & SID_WMASK;
            end
            if (flt_off == 5'h01) begin
                flt_eid_q[fid_idx_q] <= wdata_i;
            end
            if (flt_off == 5'h02) begin
                fid_idx_q <= wdata_i[3:0];
            end
        end
    end

    // Limitation: one frame header per cycle
    // Registered outputs: read data one cycle after strobe, hit result
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q   <= RST_ZERO;
            hit_q     <= 1'b0;
            hit_flt_q <= 4'h0;
            hit_ptr_q <= 4'h0;
        end else begin
            rdata_q   <= rd_i ? rmux : RST_ZERO;
            hit_q     <= frm_valid_i && any_hit;
            // Filter and pointer hold until the next frame
            if (frm_valid_i) begin
                hit_flt_q <= win_idx;
                hit_ptr_q <= win_ptr;
            end
        end
    end

    assign rdata_o      = rdata_q;
    assign hit_o        = hit_q;
    assign hit_filter_o = hit_flt_q;
    assign hit_ptr_o    = hit_ptr_q;

endmodule
`default_nettype wire

// >>> cmb_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Protocol engine stand-in: frame header, store and outcome pulses
module cmb_engine_model (
    input  wire logic                  clk_i,
    output var  logic                  frm_valid_o,
    output var  cmb_pkg::cmb_frame_t   frm_o,
    output var  logic                  store_o,
    output var  logic [4:0]            store_buf_o,
    output var  cmb_pkg::cmb_tx_result_t tx_res_o
);
    import cmb_pkg::*;
    // Idle at time zero
    initial begin
        {frm_valid_o, frm_o, store_o, store_buf_o, tx_res_o} = '0;
    end
    // One-cycle event; released fields are scrambled, never left stale
    task automatic pulse(input logic v, input cmb_frame_t f, input logic s,
                         input logic [4:0] b, input cmb_tx_result_t r);
        @(posedge clk_i);
        frm_valid_o <= v;
        frm_o       <= f;
        store_o     <= s;
        store_buf_o <= b;
        tx_res_o    <= r;
        @(posedge clk_i);
        {frm_valid_o, store_o} <= 2'b00;
        frm_o       <= ~f;
        store_buf_o <= ~b;
        tx_res_o    <= {4'h0, ~r.buf_idx};
    endtask
endmodule
`default_nettype wire

// >>> cmb_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level timing checks of the filter and buffer controller
module cmb_ctrl_checker #(
    parameter int NUM_FLT = 16,
    parameter int NUM_TRB = 8
) (
    input wire logic                    clk_i,
    input wire logic                    nrst_i,
    input wire logic [4:0]              addr_i,
    input wire logic [15:0]             wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire logic [15:0]             rdata_o,
    input wire logic                    frm_valid_i,
    input wire cmb_pkg::cmb_frame_t     frm_i,
    input wire logic                    store_i,
    input wire logic [4:0]              store_buf_i,
    input wire cmb_pkg::cmb_tx_result_t tx_res_i,
    input wire logic                    hit_o,
    input wire logic [3:0]              hit_filter_o,
    input wire logic [3:0]              hit_ptr_o,
    input wire logic [NUM_TRB-1:0]      tx_req_o,
    input wire logic [NUM_TRB-1:0]      tx_abort_o,
    input wire logic [2*NUM_TRB-1:0]    tx_pri_o,
    input wire logic [NUM_TRB-1:0]      tx_dir_o
);
    import cmb_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Software drops a pending request with no engine result racing it
    sequence sw_drop_req0;
        wr_i && addr_i == ADDR_TRCON0 && !wdata_i[CTL_REQ] && tx_req_o[0]
            && tx_res_i[6:3] == 4'h0 && !frm_valid_i;
    endsequence
    sequence abort_seen0;
        !tx_req_o[0] && tx_abort_o[0];
    endsequence
    abort_on_drop_a: assert property (sw_drop_req0 |=> abort_seen0)
        else $error("dropped request gave no abort");
    abort_pulse_a: assert property (tx_abort_o != '0 |=> (tx_abort_o & $past(tx_abort_o)) == '0)
        else $error("abort pulse longer than one cycle");
    abort_cause_a: assert property (tx_abort_o != '0 |-> (tx_abort_o & ~$past(tx_req_o)) == '0)
        else $error("abort without pending request");
    done_clears_a: assert property (tx_res_i.done && tx_res_i.buf_idx == 3'h0 && !frm_valid_i
        |=> !tx_req_o[0])
        else $error("request kept after success");
    req_set_a: assert property (wr_i && addr_i == ADDR_TRCON0 && wdata_i[CTL_REQ]
        && tx_res_i[6:3] == 4'h0 |=> tx_req_o[0])
        else $error("written request not raised");
    dir_write_a: assert property (wr_i && addr_i == ADDR_TRCON0
        |=> tx_dir_o[1:0] == {$past(wdata_i[15]), $past(wdata_i[7])})
        else $error("direction does not follow write");
    pri_write_a: assert property (wr_i && addr_i == ADDR_TRCON0
        |=> tx_pri_o[3:0] == {$past(wdata_i[9:8]), $past(wdata_i[1:0])})
        else $error("priority does not follow write");
    hit_cause_a: assert property (hit_o |-> $past(frm_valid_i))
        else $error("hit without a frame");
    ptr_hold_a: assert property (!$past(frm_valid_i) |-> $stable(hit_ptr_o))
        else $error("pointer moved without a frame");
    unmapped_rd_a: assert property (rd_i && addr_i == 5'h1F |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cmb_pkg::*;
    // Filter row: mask source, mask words, frame, expected hit
    typedef struct packed {
        logic [1:0]  sel;
        logic [15:0] msid;
        logic [15:0] meid;
        cmb_frame_t  f;
        logic        hit;
    } cmb_row_t;
    localparam cmb_row_t ROWS [9] = '{
        {2'h0, 16'hFE08, 16'h0000, 11'h123, 18'h0, 2'b10, 1'b1},
        {2'h0, 16'hFE08, 16'h0000, 11'h12F, 18'h0, 2'b10, 1'b1},
        {2'h0, 16'hFE08, 16'h0000, 11'h133, 18'h0, 2'b10, 1'b0},
        {2'h0, 16'hFE08, 16'h0000, 11'h123, 18'h0, 2'b00, 1'b0},
        {2'h1, 16'hFE00, 16'h0000, 11'h123, 18'h0, 2'b00, 1'b1},
        {2'h2, 16'hFE0B, 16'hFFFF, 11'h123, 18'h000AB, 2'b10, 1'b0},
        {2'h2, 16'hFE0B, 16'hFFFF, 11'h123, 18'h200AA, 2'b10, 1'b0},
        {2'h2, 16'hFE0B, 16'hFFFF, 11'h123, 18'h000AA, 2'b10, 1'b1},
        {2'h3, 16'hFE08, 16'h0000, 11'h123, 18'h0, 2'b10, 1'b0}};
    // Register rows: address, written word, word read back
    localparam logic [36:0] REGS [8] = '{
        {ADDR_FMSEL_LO, 16'hE4E4, 16'hE4E4}, {ADDR_FMSEL_HI, 16'h1B1B, 16'h1B1B},
        {ADDR_MSK2_SID, 16'hFFFF, SID_WMASK}, {ADDR_MSK1_EID, 16'hA5C3, 16'hA5C3},
        {ADDR_FULL_HI, 16'hFFFF, 16'h0000}, {ADDR_OVF_LO, 16'hFFFF, 16'h0000},
        {5'h0D, 16'hF0F3, 16'h8083}, {5'h1F, 16'hFFFF, 16'h0000}};
    logic               clk, nrst, wr, rd, frm_valid, store, hit;
    logic [4:0]         addr, store_buf;
    logic [15:0]        wdata, rdata, tx_pri;
    logic [3:0]         hit_flt, hit_ptr;
    logic [7:0]         tx_req, tx_abort, tx_dir;
    cmb_frame_t         frm;
    cmb_tx_result_t     tx_res;
    int                 fails = 0;
    int                 n_checks = 0;

    cmb_ctrl DUT (.clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .frm_valid_i(frm_valid), .frm_i(frm), .store_i(store),
        .store_buf_i(store_buf), .tx_res_i(tx_res), .hit_o(hit), .hit_filter_o(hit_flt),
        .hit_ptr_o(hit_ptr), .tx_req_o(tx_req), .tx_abort_o(tx_abort), .tx_pri_o(tx_pri),
        .tx_dir_o(tx_dir));
    cmb_engine_model eng (.clk_i(clk), .frm_valid_o(frm_valid), .frm_o(frm),
        .store_o(store), .store_buf_o(store_buf), .tx_res_o(tx_res));

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    // Bus master: one-cycle strobes, read data taken the cycle after
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 check(n, e, rdata);
    endtask
    task automatic frame(input cmb_frame_t f);
        eng.pulse(1'b1, f, 1'b0, 5'h00, '0);
        #1;
    endtask
    task automatic finish_test();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // 50 MHz clock and a guard against a hung run
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end
    // Main sequence: reset map, row tables, then the awkward cases
    initial begin
        {nrst, wr, rd, addr, wdata} = '0;
        repeat (10) @(posedge clk);
        check("rst_out", 16'h0000, {tx_req, tx_dir});
        nrst <= 1'b1;
        for (int a = 0; a < 23; a++) rd_chk("reset", 5'(a), a == 16 ? 16'hFFFF : 16'h0000);
        foreach (REGS[i]) begin
            wr_reg(REGS[i][36:32], REGS[i][31:16]);
            rd_chk("regs", REGS[i][36:32], REGS[i][15:0]);
        end
        // Only filter 0: identifier 0x123, extended select, pointer to FIFO
        wr_reg(ADDR_FLT_EN, 16'h0001);
        wr_reg(5'h17, 16'h0000);
        wr_reg(ADDR_FLT_SID0, 16'h2468);
        wr_reg(ADDR_FLT_EID0, 16'h00AA);
        wr_reg(ADDR_FLT_PTR0, 16'h000F);
        foreach (ROWS[i]) begin
            wr_reg(ADDR_FMSEL_LO, {14'h0, ROWS[i].sel});
            if (ROWS[i].sel != 2'h3) begin
                wr_reg(ADDR_MSK0_SID + {2'h0, ROWS[i].sel, 1'b0}, ROWS[i].msid);
                wr_reg(ADDR_MSK0_EID + {2'h0, ROWS[i].sel, 1'b0}, ROWS[i].meid);
            end
            frame(ROWS[i].f);
            check("hit", 16'(ROWS[i].hit), 16'(hit));
            if (ROWS[i].hit) check("ptr", 16'h000F, {8'h00, hit_flt, hit_ptr});
        end
        // Disabled filter, then filter 8 through the second selector word
        wr_reg(ADDR_FMSEL_LO, 16'h0000);
        wr_reg(ADDR_FLT_EN, 16'h0000);
        frame(ROWS[0].f);
        check("off", 16'h0000, 16'(hit));
        wr_reg(ADDR_FLT_EN, 16'h0100);
        wr_reg(ADDR_FMSEL_HI, 16'hC000);
        frame(31'h0);
        check("flt8", 16'h0180, {7'h0, hit, hit_flt, hit_ptr});
        wr_reg(ADDR_FMSEL_HI, 16'h0003);
        frame(31'h0);
        check("flt8_rsv", 16'h0000, 16'(hit));
        // Stores: full, overflow on a full buffer, clear by zero only
        eng.pulse(1'b0, '0, 1'b1, 5'd3, '0);
        eng.pulse(1'b0, '0, 1'b1, 5'd3, '0);
        eng.pulse(1'b0, '0, 1'b1, 5'd20, '0);
        rd_chk("full_lo", ADDR_FULL_LO, 16'h0008);
        wr_reg(ADDR_FULL_HI, 16'h0010);
        rd_chk("full_hi", ADDR_FULL_HI, 16'h0010);
        wr_reg(ADDR_FULL_LO, 16'hFFF7);
        rd_chk("full_clr", ADDR_FULL_LO, 16'h0000);
        rd_chk("ovf_lo", ADDR_OVF_LO, 16'h0008);
        wr_reg(ADDR_OVF_LO, 16'h0000);
        rd_chk("ovf_clr", ADDR_OVF_LO, 16'h0000);
        // Transmit buffer 0: outcomes, new request, abort by software
        wr_reg(ADDR_TRCON0, 16'h0088);
        #1 check("req", 16'h010D, {tx_req, tx_dir});
        eng.pulse(1'b0, '0, 1'b0, 5'h0, 7'b0010000);
        rd_chk("larb", ADDR_TRCON0, 16'h00A8);
        eng.pulse(1'b0, '0, 1'b0, 5'h0, 7'b0001000);
        rd_chk("err", ADDR_TRCON0, 16'h00B8);
        eng.pulse(1'b0, '0, 1'b0, 5'h0, 7'b1000000);
        rd_chk("done", ADDR_TRCON0, 16'h00B0);
        wr_reg(ADDR_TRCON0, 16'h0088);
        rd_chk("renew", ADDR_TRCON0, 16'h0088);
        wr_reg(ADDR_TRCON0, 16'h0080);
        #1 check("abort", 16'h0001, {14'h0, tx_req[0], tx_abort[0]});
        eng.pulse(1'b0, '0, 1'b0, 5'h0, 7'b0100000);
        rd_chk("aborted", ADDR_TRCON0, 16'h00C0);
        // Remote frame hitting buffer 0, reply disabled then enabled
        wr_reg(ADDR_FLT_EN, 16'h0001);
        wr_reg(ADDR_FLT_PTR0, 16'h0000);
        frame({11'h123, 18'h0, 2'b11});
        check("rtr_off", 16'h0000, 16'(tx_req));
        wr_reg(ADDR_TRCON0, 16'h0084);
        frame({11'h123, 18'h0, 2'b11});
        check("rtr_on", 16'h0001, 16'(tx_req));
        finish_test();
    end
endmodule

bind cmb_ctrl cmb_ctrl_checker #(.NUM_FLT(NUM_FLT), .NUM_TRB(NUM_TRB)) chk (.clk_i(clk_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .frm_valid_i(frm_valid_i), .frm_i(frm_i), .store_i(store_i),
    .store_buf_i(store_buf_i), .tx_res_i(tx_res_i), .hit_o(hit_o),
    .hit_filter_o(hit_filter_o), .hit_ptr_o(hit_ptr_o), .tx_req_o(tx_req_o),
    .tx_abort_o(tx_abort_o), .tx_pri_o(tx_pri_o), .tx_dir_o(tx_dir_o));
`default_nettype wire
